// ==== src/qdr_sram_phy.sv ====
// user-facing phy logic for a quad-rate sram: resets, calibration ready, datapath
`timescale 1ns/1ps
module qdr_sram_phy
  import qdr_phy_pkg::*;
#(
  parameter bit mask_pins_present = 1'b1  // build data mask logic; when clear the mask pins are tied low
) (
  input wire logic clk_i,                     // pll output clock, 250 mhz
  input wire logic reset_n_i,                 // global reset, async, active low
  input wire logic soft_reset_n_i,            // soft reset, async, active low
  input wire logic pll_locked_i,              // pll lock, asynchronous
  output logic pll_reset_o,                   // reset to the pll, active high
  output logic reset_request_n_o,             // low while pll unlocked
  output logic phy_clk_o,                     // user clock
  output logic reset_phy_clk_n_o,             // user domain reset, active low
  output logic usr_mode_rdy_o,                // calibration done
  input wire logic [qdr_phy_pkg::ADDR_W-1:0] wr_addr_i,  // write address
  input wire logic [qdr_phy_pkg::ADDR_W-1:0] rd_addr_i,  // read address
  input wire logic wr_sel_n_i,                // write select, active low
  input wire logic rd_sel_n_i,                // read select, active low
  input wire logic [qdr_phy_pkg::LOCAL_DW-1:0] wdata_i, // write data, two beats
  input wire logic wdata_valid_i,             // write data valid
  input wire logic [qdr_phy_pkg::BE_W-1:0] write_byte_enables_i, // byte enables
  output logic [qdr_phy_pkg::LOCAL_DW-1:0] rdata_o, // read data, two beats
  output logic rdata_valid_o,                 // read data valid
  output logic [qdr_phy_pkg::ADDR_W-1:0] mem_addr_o,    // memory address
  output logic mem_wps_n_o,                   // memory write select
  output logic mem_rps_n_o,                   // memory read select
  output logic [qdr_phy_pkg::MEM_DW-1:0] mem_d_o,       // memory write data
  output logic mem_d_oe_n_o,                  // data drive enable, low drives
  output logic [qdr_phy_pkg::MASK_W-1:0] data_mask_o,   // memory data mask, low writes
  input wire logic [qdr_phy_pkg::MEM_DW-1:0] mem_q_i    // memory read data
);
  import qdr_phy_pkg::*;

  // whole module state in one packed record
  typedef struct packed {
    logic [1:0] gsync;                 // global reset resynchroniser
    logic [1:0] ssync;                 // soft reset resynchroniser
    logic [1:0] lsync;                 // pll lock resynchroniser
    logic soft_prev;                   // soft reset level, last cycle
    logic [CNT_W-1:0] pll_cnt;         // pll reset pulse counter
    logic [CNT_W-1:0] cal_cnt;         // calibration timer
    logic rdy;                         // user mode ready
    logic [ADDR_W-1:0] addr_hi;        // write address half
    logic [ADDR_W-1:0] addr_lo;        // read address half
    logic wps_n;                       // registered write select
    logic rps_n;                       // registered read select
    logic [LOCAL_DW-1:0] wdata;        // registered write beats
    logic [BE_W-1:0] be;               // registered byte enables
    logic d_oe_n;                      // registered data output enable
    logic [RD_LAT-1:0] rd_pipe;        // read strobe delay line
    logic [MEM_DW-1:0] q_s1;           // first capture stage
    logic [MEM_DW-1:0] q_s2;           // second capture stage
    logic [MEM_DW-1:0] q_first;        // first beat of a read
    logic beat;                        // next beat is second
    logic [LOCAL_DW-1:0] rdata;        // output data register
    logic rvalid;                      // output valid register
  } phy_st_t;

  phy_st_t st_r, st_nxt;
  logic phy_rst_n;                     // internal reset for datapath
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [LOCAL_DW-1:0] fifo_in_data;
  logic fifo_out_valid;
  logic [LOCAL_DW-1:0] fifo_out_data;
  logic fifo_out_ready;

  // map byte enables of one beat onto that beat's mask pins
  function automatic logic [MASK_W-1:0] be_to_mask(input logic [BE_W-1:0] be,
                                                    input logic hi_beat);
    logic [MASK_W-1:0] m;
    m = '1;
    for (int i = 0; i < MASK_W; i++) begin
      if (hi_beat) begin
        m[i] = ~be[(MEM_DW / BYTE_BITS) + i >= BE_W ? BE_W-1 : (MEM_DW / BYTE_BITS) + i];
      end else begin
        m[i] = ~be[i >= BE_W ? BE_W-1 : i];
      end
    end
    return m;
  endfunction

  // the clock generator is outside; the user clock is our own clock
  assign phy_clk_o = clk_i;
  // user reset: async assert from global, sync release via gsync
  assign reset_phy_clk_n_o = st_r.gsync[1];
  // datapath reset also held while soft reset is low
  assign phy_rst_n = st_r.gsync[1] & st_r.ssync[1];
  assign reset_request_n_o = st_r.lsync[1];
  assign pll_reset_o = ~st_r.gsync[1] | (st_r.pll_cnt != '0);
  assign usr_mode_rdy_o = st_r.rdy;

  // pins: write address and low data beat in first half of clock, read address and high beat in second
  assign mem_addr_o = clk_i ? st_r.addr_hi : st_r.addr_lo;
  assign mem_wps_n_o = st_r.wps_n;
  assign mem_rps_n_o = st_r.rps_n;
  assign mem_d_o = clk_i ? st_r.wdata[MEM_DW-1:0] : st_r.wdata[LOCAL_DW-1:MEM_DW];
  assign mem_d_oe_n_o = st_r.d_oe_n;

  // mask pins follow byte enables only when configured, else tied low
  generate
    if (mask_pins_present) begin : g_mask
      assign data_mask_o = be_to_mask(st_r.be, ~clk_i);
    end else begin : g_nomask
      assign data_mask_o = '0;
    end
  endgenerate

  assign rdata_o = st_r.rdata;
  assign rdata_valid_o = st_r.rvalid;
  assign fifo_out_ready = 1'b1;  // controller always takes read data

  // next-state logic
  always_comb begin
    st_nxt = st_r;
    fifo_in_valid = 1'b0;
    fifo_in_data = {st_r.q_s2, st_r.q_first};
    // synchronisers: second stage reads only the first
    st_nxt.gsync = {st_r.gsync[0], 1'b1};
    st_nxt.ssync = {st_r.ssync[0], soft_reset_n_i};
    st_nxt.lsync = {st_r.lsync[0], pll_locked_i};
    st_nxt.soft_prev = st_r.ssync[1];
    // falling edge of soft reset starts the pll pulse
    if (st_r.soft_prev && !st_r.ssync[1]) begin
      st_nxt.pll_cnt = CNT_W'(PLL_PULSE_CYC);
    end else if (st_r.pll_cnt != '0) begin
      st_nxt.pll_cnt = st_r.pll_cnt - 1'b1;
    end
    // calibration waits for lock and reset release
    if (!phy_rst_n || !st_r.lsync[1] || st_r.pll_cnt != '0) begin
      st_nxt.cal_cnt = '0;
      st_nxt.rdy = 1'b0;
    end else if (st_r.cal_cnt != CNT_W'(CAL_CYC)) begin
      st_nxt.cal_cnt = st_r.cal_cnt + 1'b1;
    end else begin
      st_nxt.rdy = 1'b1;
    end
    // command path: selects ignored until ready, read select also while fifo full
    st_nxt.wps_n = wr_sel_n_i | ~st_r.rdy;
    st_nxt.rps_n = rd_sel_n_i | ~st_r.rdy | ~fifo_in_ready;
    st_nxt.addr_hi = wr_addr_i;
    st_nxt.addr_lo = rd_addr_i;
    if (wdata_valid_i) begin
      st_nxt.wdata = wdata_i;
      st_nxt.be = write_byte_enables_i;
    end
    st_nxt.d_oe_n = ~wdata_valid_i;
    // read return: delay line marks capture slots
    st_nxt.rd_pipe = {st_r.rd_pipe[RD_LAT-2:0], ~st_r.rps_n};
    st_nxt.q_s1 = mem_q_i;
    st_nxt.q_s2 = st_r.q_s1;
    // demultiplex two beats into one local word
    if (st_r.rd_pipe[RD_LAT-1]) begin
      if (!st_r.beat) begin
        st_nxt.q_first = st_r.q_s2;
        st_nxt.beat = 1'b1;
      end else begin
        st_nxt.beat = 1'b0;
        fifo_in_valid = 1'b1;
      end
    end
    // output register takes fifo head
    st_nxt.rvalid = fifo_out_valid;
    if (fifo_out_valid) begin
      st_nxt.rdata = fifo_out_data;
    end
    if (!phy_rst_n) begin
      st_nxt.rd_pipe = '0;
      st_nxt.beat = 1'b0;
      st_nxt.rvalid = 1'b0;
      st_nxt.wps_n = 1'b1;
      st_nxt.rps_n = 1'b1;
      st_nxt.d_oe_n = 1'b1;
    end
  end

  // single state register, async global reset
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r <= '{gsync: 2'h0, ssync: 2'h0, lsync: 2'h0, wps_n: 1'b1, rps_n: 1'b1,
                d_oe_n: 1'b1, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // read buffer between capture and output register
  qdr_rd_fifo #(.WIDTH(LOCAL_DW), .DEPTH(FIFO_DEPTH)) u_rd_fifo (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(fifo_in_data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data)
  );
endmodule

// small synchronous fifo used on the read data path
// it sits between the beat pairing and the output register so that a word
// completed while the output stage is busy is never lost
// the phy drains it every cycle, so in practice it holds at most one word;
// the depth is kept for a controller that may later apply back-pressure
// full and empty come straight from the occupancy count, one bit wider
// than the pointers so that a full buffer is told apart from an empty one
module qdr_rd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,              // user clock
  input wire logic reset_n_i,          // async reset, active low
  input wire logic in_valid_i,         // write side valid
  output logic in_ready_o,             // write side ready (not full)
  input wire logic [WIDTH-1:0] in_data_i, // write data
  output logic out_valid_o,            // read side valid (not empty)
  input wire logic out_ready_i,        // read side ready
  output logic [WIDTH-1:0] out_data_o  // head word
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;   // write pointer
    logic [AW-1:0] rp;   // read pointer
    logic [AW:0] cnt;    // occupancy
  } fifo_st_t;
  fifo_st_t st_r, st_nxt;
  logic [WIDTH-1:0] mem_r [DEPTH];  // storage, kept outside struct for size
  logic push, pop;

  assign in_ready_o = (st_r.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (st_r.cnt != '0);
  assign out_data_o = mem_r[st_r.rp];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  // pointer and count update
  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.wp = st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = st_r.rp + 1'b1;
    end
    if (push && !pop) begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end else if (pop && !push) begin
      st_nxt.cnt = st_r.cnt - 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // storage has no reset; only written words are ever read
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[st_r.wp] <= in_data_i;
    end
  end
endmodule

// ==== shared/qdr_phy_pkg.sv ====
// constants shared by the quad-rate sram phy block
package qdr_phy_pkg;
  localparam int ADDR_W = 20;                  // memory address width
  localparam int MEM_DW = 18;                  // memory data width (d and q buses)
  localparam int RATE = 2;                     // memory beats per user word, rate ratio
  localparam int LOCAL_DW = MEM_DW * RATE;     // local data width
  localparam int BYTE_BITS = 8;                // data bits covered by one byte enable
  localparam int BE_W = LOCAL_DW / BYTE_BITS;  // number of byte enables
  localparam int MASK_W = (MEM_DW + BYTE_BITS - 1) / BYTE_BITS; // mask pins per beat
  localparam int FIFO_DEPTH = 8;               // read data buffer depth
  localparam int CLK_MHZ = 250;                // user clock rate
  localparam int PLL_PULSE_NS = 20;            // pll reset pulse length
  localparam int PLL_PULSE_CYC = (PLL_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int CAL_NS = 400;                 // calibration time after reset
  localparam int CAL_CYC = (CAL_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 16;                   // width of timing counters
  localparam int RD_LAT = 4;                   // pipe stages from read strobe to capture
endpackage

// ==== src/qdr_rd_fifo.sv ====
// the read data fifo module is kept in qdr_sram_phy.sv beside its only user

// ==== tb/qdr_sram_phy_properties.sv ====
// checker of the phy's port relations over time
`timescale 1ns/1ps
module qdr_sram_phy_properties (
  input wire logic clk_i, // user clock
  input wire logic reset_n_i, // global reset
  input wire logic soft_reset_n_i, // soft reset
  input wire logic pll_locked_i, // pll lock
  input wire logic pll_reset_o, // pll reset
  input wire logic reset_request_n_o, // reset request
  input wire logic reset_phy_clk_n_o, // user reset
  input wire logic usr_mode_rdy_o, // ready
  input wire logic wr_sel_n_i, // write select
  input wire logic rd_sel_n_i, // read select
  input wire logic wdata_valid_i, // write valid
  input wire logic rdata_valid_o, // read valid
  input wire logic mem_wps_n_o, // mem write select
  input wire logic mem_rps_n_o, // mem read select
  input wire logic mem_d_oe_n_o // data drive enable
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // reset checking cannot be disabled by the reset itself
  property p_glob;
    disable iff (1'b0) !reset_n_i [*3] |-> pll_reset_o && !reset_phy_clk_n_o && mem_rps_n_o
      && mem_wps_n_o && !usr_mode_rdy_o;
  endproperty
  a_glob: assert property (p_glob) else $error("reset does not hold phy");
  property p_req; !pll_locked_i [*4] |-> !reset_request_n_o; endproperty
  a_req: assert property (p_req) else $error("no reset request while unlocked");
  property p_soft; $fell(soft_reset_n_i) |-> ##[1:5] pll_reset_o; endproperty
  a_soft: assert property (p_soft) else $error("no pll pulse on soft reset");
  property p_hold; !soft_reset_n_i [*4] |-> mem_rps_n_o && !rdata_valid_o; endproperty
  a_hold: assert property (p_hold) else $error("datapath runs in soft reset");
  property p_urst; $rose(reset_n_i) |-> !reset_phy_clk_n_o ##[1:3] reset_phy_clk_n_o;
  endproperty
  a_urst: assert property (p_urst) else $error("user reset release wrong");
  property p_rdy; !usr_mode_rdy_o |=> mem_rps_n_o && mem_wps_n_o; endproperty
  a_rdy: assert property (p_rdy) else $error("request passed before ready");
  property p_wr; usr_mode_rdy_o && !wr_sel_n_i |=> !mem_wps_n_o; endproperty
  a_wr: assert property (p_wr) else $error("write select not issued");
  property p_rd; rd_sel_n_i |=> mem_rps_n_o; endproperty
  a_rd: assert property (p_rd) else $error("read issued without select");
  property p_oe; 1'b1 |=> mem_d_oe_n_o != $past(wdata_valid_i); endproperty
  a_oe: assert property (p_oe) else $error("drive enable not from write valid");
  property p_pulse; rdata_valid_o |=> !rdata_valid_o; endproperty
  a_pulse: assert property (p_pulse) else $error("read valid longer than a word");
  c_rd: cover property (rdata_valid_o);
  c_wr: cover property (!mem_wps_n_o);
  c_soft: cover property ($fell(soft_reset_n_i));
endmodule

// ==== tb/qdr_mem_model.sv ====
// behavioural sram read side: answers reads after a fixed pipe
`timescale 1ns/1ps
module qdr_mem_model
  import qdr_phy_pkg::*;
(
  input wire logic clk_i, // user clock
  input wire logic mem_rps_n_i, // read select
  input wire logic [qdr_phy_pkg::ADDR_W-1:0] mem_addr_i, // address pins
  output logic [qdr_phy_pkg::MEM_DW-1:0] mem_q_o // read data
);
  logic [ADDR_W-1:0] ra; // read address seen in the low phase
  logic [ADDR_W:0] pipe [RD_LAT]; // {valid, address} per cycle
  logic [MEM_DW-1:0] last = '0; // last driven value
  // read address is muxed on the low phase; look once the mux has settled
  always @(negedge clk_i) begin
    #1;
    ra <= mem_addr_i;
  end
  // data returns a fixed pipe after the select; idle bus shows the inverse
  always @(posedge clk_i) begin
    for (int i = RD_LAT - 1; i > 0; i--) pipe[i] <= pipe[i-1];
    pipe[0] <= {!mem_rps_n_i, ra};
    last <= mem_q_o;
  end
  // beat shown so that it has passed both capture stages when rd_pipe tops out
  assign mem_q_o = (pipe[RD_LAT-3][ADDR_W] === 1'b1) ?
    (pipe[RD_LAT-3][MEM_DW-1:0] ^ 18'h2AAAA) : ~last;
endmodule

// ==== tb/qdr_sram_phy_tb_top.sv ====
// self-checking bench of the quad-rate sram phy
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
  $display("ERROR %0t mismatch", $time); end end
module qdr_sram_phy_tb_top;
  import qdr_phy_pkg::*;
  logic clk_i = 0, reset_n_i = 0, soft_n = 1, lock = 1, wsel = 1, rsel = 1, wv = 0;
  logic [ADDR_W-1:0] wa = '0, ra = '0; // addresses
  logic [LOCAL_DW-1:0] wd = '0, rdata; // data
  logic [BE_W-1:0] be = '0; // byte enables
  logic [MEM_DW-1:0] d, q; // memory pins
  logic [MASK_W-1:0] dm; // mask pins
  logic [ADDR_W-1:0] maddr; // address pins
  logic prst, rreq_n, pclk, urst_n, rdy, rv, wps_n, rps_n, oe_n;
  int n_fail = 0, checked = 0, words = 0, n;
  logic [MEM_DW-1:0] exp_q; // expected beat of the current burst
  always #2 clk_i = ~clk_i;
  qdr_sram_phy u_qdr_sram_phy (.clk_i(clk_i), .reset_n_i(reset_n_i), .soft_reset_n_i(soft_n),
    .pll_locked_i(lock), .pll_reset_o(prst), .reset_request_n_o(rreq_n), .phy_clk_o(pclk),
    .reset_phy_clk_n_o(urst_n), .usr_mode_rdy_o(rdy), .wr_addr_i(wa), .rd_addr_i(ra),
    .wr_sel_n_i(wsel), .rd_sel_n_i(rsel), .wdata_i(wd), .wdata_valid_i(wv),
    .write_byte_enables_i(be), .rdata_o(rdata), .rdata_valid_o(rv), .mem_addr_o(maddr),
    .mem_wps_n_o(wps_n), .mem_rps_n_o(rps_n), .mem_d_o(d), .mem_d_oe_n_o(oe_n),
    .data_mask_o(dm), .mem_q_i(q));
  qdr_mem_model u_qdr_mem_model (.clk_i(clk_i), .mem_rps_n_i(rps_n), .mem_addr_i(maddr),
    .mem_q_o(q));
  // every word must carry two beats of the burst address
  always @(posedge clk_i) if (rv === 1'b1) begin
    words++;
    `CHK(rdata, {exp_q, exp_q})
  end
  task automatic print_verdict();
    $display("n_fail %0d checked %0d", n_fail, checked);
    if (n_fail == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  // bounded wait for calibration done
  task automatic wait_rdy();
    for (int i = 0; i < 400 && rdy !== 1'b1; i++) cyc(1);
    `CHK(rdy, 1'b1)
    if (rdy !== 1'b1) print_verdict();
  endtask
  initial begin
    void'($urandom(99640));
    cyc(2);
    reset_n_i = 1;
    wait_rdy(); // requests only after ready
    `CHK(rreq_n, 1'b1)
    wa = $urandom;
    ra = $urandom;
    wd = LOCAL_DW'({$urandom, $urandom});
    be = '1;
    wsel = 0;
    wv = 1; // data with its valid
    cyc(3);
    `CHK(maddr, wa)
    `CHK(d, wd[MEM_DW-1:0])
    `CHK(dm, '0)
    `CHK(oe_n, 1'b0)
    @(negedge clk_i);
    #1;
    `CHK(maddr, ra)
    `CHK(d, wd[LOCAL_DW-1:MEM_DW])
    be = '0;
    cyc(2);
    `CHK(dm, '1)
    wsel = 1;
    wv = 0;
    // read bursts of random length, the last of eight words back to back
    for (int b = 0; b < 4; b++) begin
      n = (b == 3) ? 8 : 1 + $urandom % 3;
      ra = $urandom;
      exp_q = ra[MEM_DW-1:0] ^ 18'h2AAAA;
      words = 0;
      rsel = 0;
      cyc(2 * n);
      rsel = 1;
      cyc(30);
      `CHK(words, n)
    end
    lock = 0;
    cyc(5);
    `CHK(rreq_n, 1'b0)
    lock = 1;
    soft_n = 0;
    cyc(10);
    soft_n = 1;
    cyc(2);
    wait_rdy();
    reset_n_i = 0;
    #1;
    `CHK(urst_n, 1'b0)
    cyc(5);
    `CHK(prst, 1'b1)
    reset_n_i = 1;
    wait_rdy();
    print_verdict();
  end
endmodule
bind qdr_sram_phy qdr_sram_phy_properties u_qdr_sram_phy_properties (.clk_i(clk_i),
  .reset_n_i(reset_n_i), .soft_reset_n_i(soft_reset_n_i), .pll_locked_i(pll_locked_i),
  .pll_reset_o(pll_reset_o), .reset_request_n_o(reset_request_n_o),
  .reset_phy_clk_n_o(reset_phy_clk_n_o), .usr_mode_rdy_o(usr_mode_rdy_o),
  .wr_sel_n_i(wr_sel_n_i), .rd_sel_n_i(rd_sel_n_i), .wdata_valid_i(wdata_valid_i),
  .rdata_valid_o(rdata_valid_o), .mem_wps_n_o(mem_wps_n_o), .mem_rps_n_o(mem_rps_n_o),
  .mem_d_oe_n_o(mem_d_oe_n_o));
